// ---- core/sram_cyc_pkg.sv ----
// shared constants and types for the pipelined sram cycle control
// assumes a single clock domain; no register bus, every control is a pin
package sram_cyc_pkg;
   // ************************************************************
   // widths and pipeline figures
   // ************************************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int BURST_W = 2;
   localparam int SYNC_STAGES = 3;
   localparam logic [BURST_W-1:0] BEAT_RESET = 2'h0;
   localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;

   // ************************************************************
   // cycle actions chosen on each enabled edge
   // ************************************************************
   typedef enum logic [2:0] {
      ACT_DESELECT = 3'h0,
      ACT_SLEEP = 3'h1,
      ACT_RD_EXT = 3'h2,
      ACT_RD_NEXT = 3'h3,
      ACT_RD_CUR = 3'h4,
      ACT_WR_EXT = 3'h5,
      ACT_WR_NEXT = 3'h6,
      ACT_WR_CUR = 3'h7
   } action_t;
endpackage

// ---- core/burst_if.sv ----
// carrier between the cycle control and its burst counter
// assumes both ends sit on sys_clk
`timescale 1ns/10ps
interface burst_if;
   logic load;
   logic advance;
   logic linear;
   logic [sram_cyc_pkg::BURST_W-1:0] start_lsb;
   logic [sram_cyc_pkg::BURST_W-1:0] nxt;
   modport ctrl (output load, output advance, output linear, output start_lsb, input nxt);
   modport cnt (input load, input advance, input linear, input start_lsb, output nxt);
endinterface

// ---- core/burst_counter.sv ----
// two-bit wrapping burst counter, interleaved or linear order
// assumes load and advance are never requested on the same edge
`timescale 1ns/10ps
module burst_counter (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   burst_if.cnt bif
);
   logic [sram_cyc_pkg::BURST_W-1:0] start_q;
   logic [sram_cyc_pkg::BURST_W-1:0] beat_q;
   logic [sram_cyc_pkg::BURST_W-1:0] beat_inc;

   // order of beats: xor for interleaved, modulo add for linear
   function automatic logic [sram_cyc_pkg::BURST_W-1:0] beat_addr(
      input logic [sram_cyc_pkg::BURST_W-1:0] start,
      input logic [sram_cyc_pkg::BURST_W-1:0] beat,
      input logic linear);
      beat_addr = linear ? start + beat : start ^ beat;
   endfunction

   assign beat_inc = beat_q + sram_cyc_pkg::BEAT_STEP;
   assign bif.nxt = beat_addr(start_q, beat_inc, bif.linear); // see RULE_18 see RULE_19

   // start captured from the low address bits, beat wraps by width
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_q <= 2'h0;
         beat_q <= 2'h0;
      end else if (clk_en && bif.load) begin
         start_q <= bif.start_lsb; // see RULE_18
         beat_q <= sram_cyc_pkg::BEAT_RESET;
      end else if (clk_en && bif.advance) begin
         beat_q <= beat_inc;
      end
   end
endmodule

// ---- core/pipelined_sram_cycle_control.sv ----
// cycle control, byte-write decode and core array of a pipelined burst sram
// assumes the far party shares sys_clk; only sleep_request is asynchronous
//
// Overview of operation
// RULE_01: bad chip selects with a starting strobe, or ctrl strobe unselected, deselect.
// RULE_02: all selects active: proc strobe, or ctrl strobe without write, begins read.
// RULE_03: proc strobe low always starts a read, write inputs ignored.
// RULE_04: no start, advance low, reading: continue read at next burst address.
// RULE_05: no start, advance high, reading: suspend, reread current address.
// RULE_06: ctrl strobe with write request writes external address, pins undriven.
// RULE_07: no start, advance high, write request: write at current address.
// RULE_08: writes only follow a proc-strobe start or come with ctrl strobe.
// RULE_09: no start, advance low, write request: continue write at next address.
// RULE_10: no start, advance high during write burst: write again current address.
// RULE_11: sleep high ignores all controls, uses no address, floats data pins.
// RULE_12: output enable acts combinationally on drivers, never clocked.
// RULE_13: output drivers stay off during any write cycle.
// RULE_14: far party raises output enable before a write starts.
// RULE_15: reads drive data when output enable active, float otherwise or deselected.
// RULE_16: global write writes all bytes; byte enable with selects writes chosen bytes.
// RULE_17: each byte select gates its own eight data bits; others keep contents.
// RULE_18: two-bit wrapping counter from low address bits, xor or increment.
// RULE_19: static order input picks interleaved or linear sequence.
// RULE_20: first access cycle after deselect keeps outputs floating.
// RULE_21: read data goes through output register, appears one edge later.
// RULE_22: continued and suspended reads keep the same one-cycle latency.
`timescale 1ns/10ps
module pipelined_sram_cycle_control #(
   parameter int ADDR_W = sram_cyc_pkg::ADDR_W,
   parameter int DATA_W = sram_cyc_pkg::DATA_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic sleep_request,
   input wire logic chip_sel_a_n,
   input wire logic chip_sel_b,
   input wire logic chip_sel_c_n,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic global_write_n,
   input wire logic byte_write_en_n,
   input wire logic [DATA_W/sram_cyc_pkg::BYTE_W-1:0] byte_select_n,
   input wire logic burst_linear,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic out_en_n,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n
);
   localparam int BYTES = DATA_W / sram_cyc_pkg::BYTE_W;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam int BW = sram_cyc_pkg::BYTE_W;

   // ************************************************************
   // sleep pin synchroniser
   // ************************************************************
   logic [sram_cyc_pkg::SYNC_STAGES-1:0] sleep_sync_q;
   logic sleep_q;

   // level accepted only once second and third stage agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_sync_q <= '0;
         sleep_q <= 1'b0;
      end else if (clk_en) begin
         sleep_sync_q <= {sleep_sync_q[1:0], sleep_request};
         if (sleep_sync_q[1] == sleep_sync_q[2]) begin
            sleep_q <= sleep_sync_q[2];
         end
      end
   end

   // ************************************************************
   // cycle decode
   // ************************************************************
   burst_if bif ();
   sram_cyc_pkg::action_t act;
   logic active_q;
   logic rd_cyc_q;
   logic wr_cyc_q;
   logic first_q;
   logic drive_q;
   logic [ADDR_W-1:0] core_addr_q;
   logic [ADDR_W-1:0] core_addr_d;
   logic [DATA_W-1:0] dout_q;
   wire [DATA_W-1:0] rd_word;
   logic [BYTES-1:0] byte_we;
   wire proc_start = !proc_addr_strobe_n && !chip_sel_a_n;
   wire ctrl_start = !ctrl_addr_strobe_n;
   wire any_start = proc_start || ctrl_start;
   wire sel_ok = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
   wire wr_req = !global_write_n || (!byte_write_en_n && !(&byte_select_n));
   wire deselect = (ctrl_start && chip_sel_a_n) || (any_start && !sel_ok); // see RULE_01
   wire is_ext = act == sram_cyc_pkg::ACT_RD_EXT || act == sram_cyc_pkg::ACT_WR_EXT;
   wire is_next = act == sram_cyc_pkg::ACT_RD_NEXT || act == sram_cyc_pkg::ACT_WR_NEXT;
   wire is_write = act inside {sram_cyc_pkg::ACT_WR_EXT, sram_cyc_pkg::ACT_WR_NEXT,
                               sram_cyc_pkg::ACT_WR_CUR};
   wire is_read = act inside {sram_cyc_pkg::ACT_RD_EXT, sram_cyc_pkg::ACT_RD_NEXT,
                              sram_cyc_pkg::ACT_RD_CUR};

   // priority: sleep, deselect, proc strobe, ctrl strobe, then burst control
   // a burst cannot resume from deselect, so idle without strobe stays idle
   assign act = sleep_q ? sram_cyc_pkg::ACT_SLEEP : // see RULE_11
      deselect ? sram_cyc_pkg::ACT_DESELECT : // see RULE_01
      proc_start ? sram_cyc_pkg::ACT_RD_EXT : // see RULE_02 see RULE_03
      ctrl_start ? (wr_req ? sram_cyc_pkg::ACT_WR_EXT : // see RULE_06 see RULE_08
                             sram_cyc_pkg::ACT_RD_EXT) : // see RULE_02
      !active_q ? sram_cyc_pkg::ACT_DESELECT :
      wr_req ? (burst_advance_n ? sram_cyc_pkg::ACT_WR_CUR : // see RULE_07 see RULE_10
                                  sram_cyc_pkg::ACT_WR_NEXT) : // see RULE_09
      burst_advance_n ? sram_cyc_pkg::ACT_RD_CUR : // see RULE_05
                        sram_cyc_pkg::ACT_RD_NEXT; // see RULE_04

   // address source: external, next burst beat or held current
   assign core_addr_d = is_ext ? addr :
      is_next ? {core_addr_q[ADDR_W-1:2], bif.nxt} : core_addr_q; // see RULE_04 see RULE_05
   assign bif.load = is_ext;
   assign bif.advance = is_next;
   assign bif.linear = burst_linear; // see RULE_19
   assign bif.start_lsb = addr[1:0]; // see RULE_18

   burst_counter u_burst (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .bif(bif)
   );

   // byte strobes; global write overrides the byte inputs
   assign byte_we = !is_write ? '0 :
      !global_write_n ? '1 : // see RULE_16
      !byte_write_en_n ? ~byte_select_n : '0; // see RULE_16

   // ************************************************************
   // cycle state and read pipeline
   // ************************************************************
   // drive flag lags the read by one edge, matching the data register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= 1'b0;
         rd_cyc_q <= 1'b0;
         wr_cyc_q <= 1'b0;
         first_q <= 1'b0;
         drive_q <= 1'b0;
         core_addr_q <= '0;
         dout_q <= '0;
      end else if (clk_en) begin
         active_q <= act != sram_cyc_pkg::ACT_DESELECT && act != sram_cyc_pkg::ACT_SLEEP;
         rd_cyc_q <= is_read;
         wr_cyc_q <= is_write;
         first_q <= is_read && !active_q; // see RULE_20
         // a deselect edge lets go at once, even with a read still in the pipe
         drive_q <= rd_cyc_q && !first_q && act != sram_cyc_pkg::ACT_DESELECT; // see RULE_01
         core_addr_q <= core_addr_d;
         dout_q <= rd_word; // see RULE_21 see RULE_22
      end
   end

   // core array, one write lane per byte; array is not reset
   // each lane owns its own storage so no word has two writers
   for (genvar b = 0; b < BYTES; b++) begin : g_lane
      logic [BW-1:0] lane_q [DEPTH];
      always_ff @(posedge sys_clk) begin
         if (clk_en && byte_we[b]) begin
            lane_q[core_addr_d] <= dq_in[b*BW +: BW]; // see RULE_17
         end
      end
      assign rd_word[b*BW +: BW] = lane_q[core_addr_q];
   end

   // output enable is never sampled; writes and sleep mask it
   assign dq_out = dout_q;
   assign dq_oe_n = !(drive_q && !wr_cyc_q && !sleep_q && !out_en_n); // see RULE_12 see RULE_13 see RULE_15

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_DESELECT_FLOAT: assert property ( // see RULE_01
      clk_en && act == sram_cyc_pkg::ACT_DESELECT |=> dq_oe_n)
      else $error("pins driven after deselect");
   AST_PROC_READ: assert property ( // see RULE_03
      !sleep_q && proc_start && sel_ok |-> act == sram_cyc_pkg::ACT_RD_EXT)
      else $error("proc strobe did not start read");
   AST_CTRL_READ: assert property ( // see RULE_02
      !sleep_q && !proc_start && ctrl_start && sel_ok && !wr_req
      |-> act == sram_cyc_pkg::ACT_RD_EXT)
      else $error("ctrl strobe read not started");
   AST_CONT_READ: assert property ( // see RULE_04
      clk_en && act == sram_cyc_pkg::ACT_RD_NEXT |=> core_addr_q[1:0] == $past(bif.nxt))
      else $error("burst did not advance");
   AST_SUSP_READ: assert property ( // see RULE_05
      clk_en && act == sram_cyc_pkg::ACT_RD_CUR |=> $stable(core_addr_q))
      else $error("suspended read moved address");
   AST_WRITE_MASK: assert property ( // see RULE_13
      clk_en && is_write |=> dq_oe_n)
      else $error("pins driven in write cycle");
   AST_OE_ASYNC: assert property ( // see RULE_12
      out_en_n |-> dq_oe_n)
      else $error("drive without output enable");
   AST_GLOBAL_WRITE: assert property ( // see RULE_16
      is_write && !global_write_n |-> &byte_we)
      else $error("global write missed a byte");
   AST_FIRST_FLOAT: assert property ( // see RULE_20
      clk_en && is_read && !active_q ##1 clk_en |=> dq_oe_n)
      else $error("first cycle after deselect drove pins");
   AST_READ_LAT: assert property ( // see RULE_21
      clk_en && is_read && active_q && !sleep_q ##1
      clk_en && !sleep_q && act != sram_cyc_pkg::ACT_DESELECT |=> drive_q)
      else $error("read data not presented after one edge");
   AST_SLEEP_IDLE: assert property ( // see RULE_11
      clk_en && sleep_q |=> !active_q && dq_oe_n)
      else $error("sleep left device active");
endmodule

// ---- test/sram_host_model.sv ----
// far-side bus model: resolves the shared data lines for the bench
// assumes host_data and host_drive change only off the rising edge
`timescale 1ns/10ps
module sram_host_model (
   input wire logic sys_clk,
   input wire logic [31:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic [31:0] host_data,
   input wire logic host_drive,
   output logic [31:0] dq_bus
);
   logic [31:0] last_q = 32'h0;
   // released lines show the inverse of the last level, never a stale copy
   always @(posedge sys_clk) begin
      last_q <= dq_bus;
   end
   // host data only wins once the device has let go
   assign dq_bus = !dq_oe_n ? dq_out : (host_drive ? host_data : ~last_q);
endmodule

// ---- test/pipelined_sram_cycle_control_tb_top.sv ----
// self-checking bench for the pipelined sram cycle control
// assumes a 4-bit address build and the bus model in sram_host_model
`timescale 1ns/10ps
module pipelined_sram_cycle_control_tb_top;
   logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, sleep_request = 1'b0;
   logic chip_sel_a_n = 1'b0, chip_sel_b = 1'b1, chip_sel_c_n = 1'b0;
   logic pa_n = 1'b1, sa_n = 1'b1, adv_n = 1'b1, gw_n = 1'b1, bwe_n = 1'b1;
   logic burst_linear = 1'b0, out_en_n = 1'b0, host_drive = 1'b0, dq_oe_n;
   logic [3:0] bs_n = 4'hF, addr = 4'h0;
   logic [31:0] host_data = 32'h0, dq_bus, dq_out;
   logic [31:0] mem [16];
   logic [2:0] cs_next = 3'b010;
   int err_count = 0, checks = 0, cycles = 0, seed = 32'hfedf;

   always #5 sys_clk = ~sys_clk;

   pipelined_sram_cycle_control #(.ADDR_W(4)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .clk_en(clk_en), .sleep_request(sleep_request), .chip_sel_a_n(chip_sel_a_n),
      .chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n), .proc_addr_strobe_n(pa_n),
      .ctrl_addr_strobe_n(sa_n), .burst_advance_n(adv_n), .global_write_n(gw_n),
      .byte_write_en_n(bwe_n), .byte_select_n(bs_n), .burst_linear(burst_linear),
      .addr(addr), .out_en_n(out_en_n), .dq_in(dq_bus), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
   sram_host_model host (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .host_data(host_data), .host_drive(host_drive), .dq_bus(dq_bus));

   // ****************************************
   // helpers
   // ****************************************
   task results();
      if (err_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // burst address of beat k from start a in the current order
   function automatic logic [3:0] nxt(input logic [3:0] a, input logic [1:0] k);
      return {a[3:2], burst_linear ? a[1:0] + k : a[1:0] ^ k};
   endfunction

   // word after a write with the controls now on the pins
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d);
      merge = o;
      if (!gw_n) merge = d;
      else if (!bwe_n) begin
         for (int i = 0; i < 4; i++) begin
            if (!bs_n[i]) merge[8*i+:8] = d[8*i+:8];
         end
      end
   endfunction

   // one bus cycle: drive at the falling edge, settle 1 ns past the rise
   task cyc(input logic p, s, v, g, b, input logic [3:0] m, a, input logic [31:0] d);
      @(negedge sys_clk);
      {pa_n, sa_n, adv_n, gw_n, bwe_n, bs_n, addr, host_data} = {p, s, v, g, b, m, a, d};
      {chip_sel_a_n, chip_sel_b, chip_sel_c_n} = cs_next;
      host_drive = p & (!g | !b);
      // host releases the device drivers in the same step as it puts write data on the lines
      out_en_n = p & (!g | !b);
      @(posedge sys_clk);
      #1;
   endtask

   task idle();
      cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 4'h0, 32'h0);
   endtask

   // enable drops again after the write edge so the write mask is exercised
   task wr(input logic [3:0] a, input logic [31:0] d, input logic g, b, input logic [3:0] m);
      cyc(1'b1, 1'b0, 1'b1, g, b, m, a, d);
      mem[a] = merge(mem[a], d);
      out_en_n = 1'b0;
      #1;
      if (!g || (!b && m != 4'hF)) chk(32'h1, {31'h0, dq_oe_n});
   endtask

   // start, three advances, then two suspends on the last beat
   task rd(input logic [3:0] a, input logic fresh);
      for (int k = 0; k < 6; k++) begin
         if (k == 0) cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, a, 32'h0);
         else cyc(1'b1, 1'b1, k > 3, 1'b1, 1'b1, 4'hF, 4'h0, 32'h0);
         if (k > 0) begin
            chk(mem[nxt(a, (k > 4) ? 2'h3 : 2'(k - 1))], dq_out);
            chk({31'h0, fresh && k == 1}, {31'h0, dq_oe_n});
         end
      end
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         results();
      end
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      logic [3:0] a;
      logic [31:0] o;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      for (int i = 0; i < 16; i++) wr(4'(i), $random(seed), 1'b0, 1'b1, 4'h0);
      for (int i = 0; i < 16; i++) wr(4'(i), $random(seed), 1'b1, 1'b0, 4'(i));
      wr(4'h3, $random(seed), 1'b1, 1'b1, 4'h0);
      for (int l = 0; l < 2; l++) begin
         burst_linear = l[0];
         rd(4'h3, 1'b0);
         rd(4'($random(seed)), 1'b0);
      end
      // mid-cycle enable toggles must reach the drivers at once
      #1 out_en_n = 1'b1;
      #1 chk(32'h1, {31'h0, dq_oe_n});
      out_en_n = 1'b0;
      #1 chk(32'h0, {31'h0, dq_oe_n});
      // processor start with write inputs, then current, next, repeated write
      a = 4'($random(seed));
      o = mem[a];
      cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, a, ~o);
      cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 4'h0, ~o);
      chk(o, dq_out);
      mem[a] = ~o;
      cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 4'h0, o + 1);
      mem[nxt(a, 2'h1)] = o + 1;
      cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h5, 4'h0, ~o);
      mem[nxt(a, 2'h1)] = merge(mem[nxt(a, 2'h1)], ~o);
      out_en_n = 1'b0;
      #1 chk(32'h1, {31'h0, dq_oe_n});
      rd(a, 1'b0);
      // each deselect cause, carrying a write that must not land
      for (int j = 0; j < 3; j++) begin
         wr(a, $random(seed), 1'b0, 1'b1, 4'hF);
         idle();
         cs_next = (j == 0) ? 3'b110 : (j == 1) ? 3'b011 : 3'b000;
         cyc(j != 1, j == 1, 1'b1, 1'b0, 1'b1, 4'hF, a, ~mem[a]);
         cs_next = 3'b010;
         idle();
         chk(32'h1, {31'h0, dq_oe_n});
         rd(a, 1'b1);
      end
      // sleep ignores a write and floats the pins
      sleep_request = 1'b1;
      repeat (4) idle();
      cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, a, ~mem[a]);
      out_en_n = 1'b0;
      #1 chk(32'h1, {31'h0, dq_oe_n});
      sleep_request = 1'b0;
      repeat (4) idle();
      rd(a, 1'b1);
      results();
   end
endmodule
